// >>> line_debouncer.sv
// Level debouncer for one trigger line.
// Assumes the raw input is already synchronous to the clock.
`timescale 1ns/100ps
`default_nettype none
module line_debouncer #(
  parameter int CW = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Line and setting.
  input wire logic raw,
  input wire logic [CW-1:0] limit,
  // Filtered level.
  output logic filtered
);

  logic [CW-1:0] cnt; // Cycles the raw level has differed from the filtered one.

  // ---------------------------------------------------------------------------
  // Filter
  // ---------------------------------------------------------------------------
  // A change is taken only after it has stood for the whole limit, so a short
  // pulse never reaches the filtered level; both edges are delayed alike, which
  // keeps the width of an accepted pulse intact.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      filtered <= 1'b0;
    end else if (raw == filtered) begin
      cnt <= '0;
    end else if (cnt + 1'b1 >= limit) begin
      cnt <= '0;
      filtered <= raw;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

endmodule
`default_nettype wire

// >>> trig_pkg.sv
// Shared constants and types for the trigger and exposure control block.
// Assumes a single 20 MHz clock and an AXI4-Lite register port with byte addresses.
package trig_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ = 20;                  // Reference clock rate in MHz.
  localparam int DEBOUNCE_TIME_NS = 1000;       // Default debounce time in ns.
  localparam int DEBOUNCE_CYCLES = (DEBOUNCE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int EXPOSURE_TIME_US = 45345;      // Default exposure time in us.
  localparam int EXPOSURE_CYCLES = EXPOSURE_TIME_US * CLK_MHZ;
  localparam int DELAY_POS_NS = 4400;           // Recognition delay, positive polarity.
  localparam int DELAY_POS_CYCLES = (DELAY_POS_NS * CLK_MHZ) / 1000;
  localparam int DELAY_NEG_NS = 53200;          // Recognition delay, negative polarity.
  localparam int DELAY_NEG_CYCLES = (DELAY_NEG_NS * CLK_MHZ) / 1000;
  localparam int READOUT_TIME_US = 100;         // Default image output time in us.
  localparam int READOUT_CYCLES = READOUT_TIME_US * CLK_MHZ;
  localparam int STROBE_LEN_NS = 1000;          // Default strobe length in ns.
  localparam int STROBE_LEN_CYCLES = (STROBE_LEN_NS * CLK_MHZ + 999) / 1000;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DEBOUNCE = 8'h04;
  localparam logic [7:0] ADDR_EXPOSURE = 8'h08;
  localparam logic [7:0] ADDR_TRIG_DELAY = 8'h0C;
  localparam logic [7:0] ADDR_STROBE_START_OFFSET = 8'h10;
  localparam logic [7:0] ADDR_STROBE_LENGTH = 8'h14;
  localparam logic [7:0] ADDR_READOUT = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;

  // ---------------------------------------------------------------------------
  // Control fields and reset values
  // ---------------------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;             // Two-bit operating mode.
  localparam int CTRL_POL_BIT = 2;              // 1 = positive polarity.
  localparam int CTRL_SRC_BIT = 3;              // 0 = isolated input, 1 = open-collector line.
  localparam int CTRL_SWTRIG_BIT = 4;           // Write 1 for a software trigger.
  localparam int CTRL_OCOUT_BIT = 5;            // 1 = open-collector line drives the strobe.
  localparam logic [1:0] CTRL_MODE_RESET = 2'h0;
  localparam logic CTRL_POL_RESET = 1'b1;
  localparam logic [15:0] DEBOUNCE_RESET = 16'(DEBOUNCE_CYCLES);
  localparam logic [15:0] DELAY_POS_RESET = 16'(DELAY_POS_CYCLES);
  localparam logic [15:0] DELAY_NEG_RESET = 16'(DELAY_NEG_CYCLES);
  localparam logic [15:0] STROBE_OFFSET_RESET = 16'h0000;
  localparam logic [15:0] STROBE_LEN_RESET = 16'(STROBE_LEN_CYCLES);

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Operating modes.
  typedef enum logic [1:0] {
    MODE_FREE_RUN = 2'b00,
    MODE_PULSE_WIDTH = 2'b01,
    MODE_EDGE_PRESET = 2'b10,
    MODE_EDGE_GUARDED = 2'b11
  } trig_mode_t;

  // Frame sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_EXPOSE = 2'b10,
    ST_READOUT = 2'b11
  } frame_state_t;

endpackage

// >>> trig_source.sv
// Model of the external trigger source on the trigger lines.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module trig_source (
  // Clock.
  input wire logic clk,
  // Driven trigger level.
  output logic line
);
  initial line = 1'b0;
  // Park the line at its inactive level between pulses.
  task automatic set_idle(input logic lvl);
    line <= lvl;
  endtask
  // Hold the active level n cycles; short values break the hold on purpose.
  task automatic pulse(input logic act, input int n);
    line <= act;
    repeat (n) @(posedge clk);
    line <= !act;
  endtask
endmodule
`default_nettype wire

// >>> trigger_exposure_control.sv
// Trigger-driven exposure sequencer with an AXI4-Lite register port.
// Assumes trigger pins are synchronous to REF_CLK and the bus master keeps one
// write and one read outstanding at most.
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module trigger_exposure_control #(
  parameter logic [23:0] EXPOSURE_RESET = 24'(trig_pkg::EXPOSURE_CYCLES),
  parameter logic [15:0] READOUT_RESET = 16'(trig_pkg::READOUT_CYCLES)
) (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RST_B,
  // AXI4-Lite write channels.
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read channels.
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Trigger lines.
  input wire logic ISOLATED_TRIGGER_INPUT,
  input wire logic OPEN_COLLECTOR_IO_LINE_IN,
  output logic OPEN_COLLECTOR_IO_LINE_OUT,
  output logic OPEN_COLLECTOR_IO_LINE_OE,
  // Camera timing outputs.
  output logic EXPOSURE_ACTIVE,
  output logic FRAME_TRIGGER,
  output logic FRAME_BUSY,
  output logic STROBE
);

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  logic [1:0] rst_pipe; // Release pipeline for the asynchronous reset.
  logic rst_n; // Reset copy used by all logic.

  // The reset asserts at once and releases two edges later, clear of the clock.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [1:0] mode; // Operating mode.
  logic pol; // Trigger polarity, 1 = positive.
  logic src; // Trigger source select.
  logic ocout; // Open-collector line used as strobe output.
  logic sw_trig; // One-cycle software trigger.
  logic [15:0] debounce_limit; // Debounce time in cycles.
  logic [23:0] exposure_time; // Stored exposure time in cycles.
  logic [15:0] delay_pos; // Recognition delay for positive polarity.
  logic [15:0] delay_neg; // Recognition delay for negative polarity.
  logic [15:0] strobe_start_offset; // Cycles from frame trigger to strobe.
  logic [15:0] strobe_length; // Strobe length in cycles.
  logic [15:0] readout_time; // Image output time in cycles.
  logic [15:0] frame_count; // Frames started since reset.
  logic [7:0] aw_addr; // Latched write address.
  logic [31:0] w_data; // Latched write data.
  logic [3:0] w_strb; // Latched write strobes.
  logic aw_held; // Write address taken.
  logic w_held; // Write data taken.
  trig_pkg::frame_state_t state; // Frame sequencer state.
  logic iso_filt; // Debounced isolated input.
  logic oc_filt; // Debounced open-collector line.

  // Write decode: a write fires once both halves are held and no response waits.
  wire do_write = aw_held && w_held && !S_AXI_BVALID;
  wire wr_ctrl = do_write && aw_addr == trig_pkg::ADDR_CTRL;
  wire wr_deb = do_write && aw_addr == trig_pkg::ADDR_DEBOUNCE;
  wire wr_exp = do_write && aw_addr == trig_pkg::ADDR_EXPOSURE;
  wire wr_dly = do_write && aw_addr == trig_pkg::ADDR_TRIG_DELAY;
  wire wr_sso = do_write && aw_addr == trig_pkg::ADDR_STROBE_START_OFFSET;
  wire wr_sl = do_write && aw_addr == trig_pkg::ADDR_STROBE_LENGTH;
  wire wr_ro = do_write && aw_addr == trig_pkg::ADDR_READOUT;
  wire wr_ok = wr_ctrl || wr_deb || wr_exp || wr_dly || wr_sso || wr_sl || wr_ro ||
               aw_addr == trig_pkg::ADDR_STATUS;
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] wval = w_data & wmask;

  // Read decode and mux.
  wire [31:0] status_word = {frame_count, 10'h000, oc_filt, iso_filt, state,
                             FRAME_BUSY, EXPOSURE_ACTIVE};
  wire rd_hit = S_AXI_ARADDR[7:5] == 3'h0 && S_AXI_ARADDR[1:0] == 2'h0;
  wire [31:0] rd_word =
    S_AXI_ARADDR == trig_pkg::ADDR_CTRL ? {26'h0000000, ocout, 1'b0, src, pol, mode} :
    S_AXI_ARADDR == trig_pkg::ADDR_DEBOUNCE ? {16'h0000, debounce_limit} :
    S_AXI_ARADDR == trig_pkg::ADDR_EXPOSURE ? {8'h00, exposure_time} :
    S_AXI_ARADDR == trig_pkg::ADDR_TRIG_DELAY ? {delay_neg, delay_pos} :
    S_AXI_ARADDR == trig_pkg::ADDR_STROBE_START_OFFSET ? {16'h0000, strobe_start_offset} :
    S_AXI_ARADDR == trig_pkg::ADDR_STROBE_LENGTH ? {16'h0000, strobe_length} :
    S_AXI_ARADDR == trig_pkg::ADDR_READOUT ? {16'h0000, readout_time} :
    S_AXI_ARADDR == trig_pkg::ADDR_STATUS ? status_word : 32'h00000000;

  // Bus handshakes; each half of a write is held until the response goes out.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= trig_pkg::RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= !aw_held && !S_AXI_AWREADY && !S_AXI_AWVALID ? 1'b1 :
                       !(S_AXI_AWVALID && S_AXI_AWREADY) && !aw_held;
      S_AXI_WREADY <= !(S_AXI_WVALID && S_AXI_WREADY) && !w_held;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (do_write) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_ok ? trig_pkg::RESP_OKAY : trig_pkg::RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  // Read channel: one cycle from address to data, held until taken.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= trig_pkg::RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_word;
        S_AXI_RRESP <= rd_hit ? trig_pkg::RESP_OKAY : trig_pkg::RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // Configuration registers; unused strobe lanes keep their old bytes out.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      mode <= trig_pkg::CTRL_MODE_RESET;
      pol <= trig_pkg::CTRL_POL_RESET;
      src <= 1'b0;
      ocout <= 1'b0;
      sw_trig <= 1'b0;
      debounce_limit <= trig_pkg::DEBOUNCE_RESET;
      exposure_time <= EXPOSURE_RESET;
      delay_pos <= trig_pkg::DELAY_POS_RESET;
      delay_neg <= trig_pkg::DELAY_NEG_RESET;
      strobe_start_offset <= trig_pkg::STROBE_OFFSET_RESET;
      strobe_length <= trig_pkg::STROBE_LEN_RESET;
      readout_time <= READOUT_RESET;
    end else begin
      sw_trig <= wr_ctrl && w_strb[0] && w_data[trig_pkg::CTRL_SWTRIG_BIT];
      if (wr_ctrl && w_strb[0]) begin
        mode <= w_data[trig_pkg::CTRL_MODE_LSB +: 2];
        pol <= w_data[trig_pkg::CTRL_POL_BIT];
        src <= w_data[trig_pkg::CTRL_SRC_BIT];
        ocout <= w_data[trig_pkg::CTRL_OCOUT_BIT];
      end
      if (wr_deb) debounce_limit <= (wval[15:0]) | (debounce_limit & ~wmask[15:0]);
      if (wr_exp) exposure_time <= wval[23:0] | (exposure_time & ~wmask[23:0]);
      if (wr_dly) delay_pos <= wval[15:0] | (delay_pos & ~wmask[15:0]);
      if (wr_dly) delay_neg <= wval[31:16] | (delay_neg & ~wmask[31:16]);
      if (wr_sso) strobe_start_offset <= wval[15:0] | (strobe_start_offset & ~wmask[15:0]);
      if (wr_sl) strobe_length <= wval[15:0] | (strobe_length & ~wmask[15:0]);
      if (wr_ro) readout_time <= wval[15:0] | (readout_time & ~wmask[15:0]);
    end
  end

  // ---------------------------------------------------------------------------
  // Trigger conditioning
  // ---------------------------------------------------------------------------
  line_debouncer #(.CW(16)) iso_filter (
    .clk(REF_CLK), .rst_n(rst_n), .raw(ISOLATED_TRIGGER_INPUT),
    .limit(debounce_limit), .filtered(iso_filt)
  );
  line_debouncer #(.CW(16)) oc_filter (
    .clk(REF_CLK), .rst_n(rst_n), .raw(OPEN_COLLECTOR_IO_LINE_IN),
    .limit(debounce_limit), .filtered(oc_filt)
  );

  logic active_q; // Previous active level of the chosen line.
  wire filt_sel = src ? oc_filt : iso_filt;
  wire active_lvl = pol ? filt_sel : !filt_sel;
  wire act_start = active_lvl && !active_q;
  wire act_end = !active_lvl && active_q;
  wire [15:0] rec_delay = pol ? delay_pos : delay_neg;

  // ---------------------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------------------
  logic [15:0] dly_cnt; // Cycles left before the frame trigger.
  logic [23:0] ex_cnt; // Cycles already exposed.
  logic [23:0] pw_len; // Measured active pulse length.
  logic pulse_on; // Pulse being measured.
  logic pulse_done; // Pulse end seen.
  logic [15:0] ro_cnt; // Image output cycles elapsed.
  trig_pkg::frame_state_t next_state; // Sequencer state after this edge.
  logic next_frame; // Frame trigger this cycle.

  wire pw_mode = mode == trig_pkg::MODE_PULSE_WIDTH;
  wire edge_req = (act_start || sw_trig) && mode[1];
  // Plain edge preset may restart during image output; the guarded one may not.
  wire accept = state == trig_pkg::ST_IDLE ? (edge_req || pw_mode && act_start) :
                state == trig_pkg::ST_READOUT && mode == trig_pkg::MODE_EDGE_PRESET && edge_req;
  wire [23:0] ex_target = pw_mode ? pw_len : exposure_time;
  wire ex_last = (ex_cnt + 24'h000001 >= ex_target) && (!pw_mode || pulse_done);
  wire ro_last = ro_cnt + 16'h0001 >= readout_time;

  // Next-state decode; a trigger in a busy state is simply dropped, except an edge-preset one during image output.
  always_comb begin
    next_state = state;
    next_frame = 1'b0;
    unique case (state)
      trig_pkg::ST_IDLE: begin
        if (mode == trig_pkg::MODE_FREE_RUN) begin
          next_state = trig_pkg::ST_EXPOSE;
          next_frame = 1'b1;
        end else if (accept) begin
          next_state = trig_pkg::ST_DELAY;
        end
      end
      trig_pkg::ST_DELAY: begin
        if (dly_cnt == 16'h0000) begin
          next_state = trig_pkg::ST_EXPOSE;
          next_frame = 1'b1;
        end
      end
      trig_pkg::ST_EXPOSE: begin
        if (ex_last) next_state = trig_pkg::ST_READOUT;
      end
      trig_pkg::ST_READOUT: begin
        if (accept) next_state = trig_pkg::ST_DELAY;
        else if (ro_last) next_state = trig_pkg::ST_IDLE;
      end
    endcase
  end

  // Counters and flags of the sequencer.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= trig_pkg::ST_IDLE;
      active_q <= 1'b0;
      dly_cnt <= 16'h0000;
      ex_cnt <= 24'h000000;
      ro_cnt <= 16'h0000;
      pw_len <= 24'h000000;
      pulse_on <= 1'b0;
      pulse_done <= 1'b0;
      frame_count <= 16'h0000;
    end else begin
      state <= next_state;
      active_q <= active_lvl;
      dly_cnt <= accept ? rec_delay : (dly_cnt != 16'h0000 ? dly_cnt - 16'h0001 : dly_cnt);
      ex_cnt <= next_frame ? 24'h000000 : ex_cnt + 24'h000001;
      ro_cnt <= state == trig_pkg::ST_EXPOSE ? 16'h0000 : ro_cnt + 16'h0001;
      if (accept && pw_mode) begin
        pulse_on <= 1'b1;
        pulse_done <= 1'b0;
        pw_len <= 24'h000001;
      end else if (pulse_on && act_end) begin
        pulse_on <= 1'b0;
        pulse_done <= 1'b1;
      end else if (pulse_on && pw_len != 24'hFFFFFF) begin
        pw_len <= pw_len + 24'h000001;
      end
      if (next_frame) frame_count <= frame_count + 16'h0001;
    end
  end

  // ---------------------------------------------------------------------------
  // Timing outputs and strobe timer
  // ---------------------------------------------------------------------------
  logic strobe_wait; // Counting the strobe start offset.
  logic [15:0] st_cnt; // Strobe timer count.

  // The strobe timer restarts on each frame trigger; a new frame cuts an old strobe.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      EXPOSURE_ACTIVE <= 1'b0;
      FRAME_TRIGGER <= 1'b0;
      FRAME_BUSY <= 1'b0;
      STROBE <= 1'b0;
      strobe_wait <= 1'b0;
      st_cnt <= 16'h0000;
      OPEN_COLLECTOR_IO_LINE_OUT <= 1'b0;
      OPEN_COLLECTOR_IO_LINE_OE <= 1'b0;
    end else begin
      EXPOSURE_ACTIVE <= next_state == trig_pkg::ST_EXPOSE;
      FRAME_TRIGGER <= next_frame;
      FRAME_BUSY <= next_state != trig_pkg::ST_IDLE;
      OPEN_COLLECTOR_IO_LINE_OUT <= 1'b0;
      if (next_frame) begin
        strobe_wait <= strobe_start_offset != 16'h0000;
        STROBE <= strobe_start_offset == 16'h0000 && strobe_length != 16'h0000;
        st_cnt <= strobe_start_offset == 16'h0000 ? strobe_length - 16'h0001 :
                  strobe_start_offset - 16'h0001;
      end else if (strobe_wait) begin
        if (st_cnt == 16'h0000) begin
          strobe_wait <= 1'b0;
          STROBE <= strobe_length != 16'h0000;
          st_cnt <= strobe_length - 16'h0001;
        end else begin
          st_cnt <= st_cnt - 16'h0001;
        end
      end else if (STROBE) begin
        if (st_cnt == 16'h0000) STROBE <= 1'b0;
        else st_cnt <= st_cnt - 16'h0001;
      end
      OPEN_COLLECTOR_IO_LINE_OE <= ocout && STROBE;
    end
  end

endmodule
`default_nettype wire

// >>> trigger_exposure_control_assertions.sv
// Checker for the trigger and exposure control ports.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module trigger_exposure_control_assertions (
  // Clock, reset and bus answers.
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  // Camera timing and line drive.
  input wire logic EXPOSURE_ACTIVE,
  input wire logic FRAME_TRIGGER,
  input wire logic FRAME_BUSY,
  input wire logic OPEN_COLLECTOR_IO_LINE_OUT,
  input wire logic OPEN_COLLECTOR_IO_LINE_OE
);
  // ------
  // Properties
  // ------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  a_trig_opens_exp: assert property ($rose(EXPOSURE_ACTIVE) |-> FRAME_TRIGGER)
    else $error("exposure rose without frame trigger");
  a_trig_one_cycle: assert property (FRAME_TRIGGER |=> !FRAME_TRIGGER)
    else $error("frame trigger longer than one cycle");
  a_trig_with_exp: assert property (FRAME_TRIGGER |-> EXPOSURE_ACTIVE)
    else $error("frame trigger without exposure");
  a_exp_in_busy: assert property (EXPOSURE_ACTIVE |-> FRAME_BUSY)
    else $error("exposure outside busy");
  // A new exposure may never cut into a running one.
  a_no_restart: assert property (FRAME_TRIGGER |-> !$past(EXPOSURE_ACTIVE))
    else $error("trigger accepted during exposure");
  a_readout_busy: assert property ($fell(EXPOSURE_ACTIVE) |-> FRAME_BUSY)
    else $error("busy dropped with exposure");
  a_oc_pulls_low: assert property (OPEN_COLLECTOR_IO_LINE_OE |-> !OPEN_COLLECTOR_IO_LINE_OUT)
    else $error("open collector driven high");
  a_bresp_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
  a_rdata_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
endmodule
`default_nettype wire

// >>> trigger_exposure_control_test.sv
// Self-checking bench for the trigger and exposure control block.
// Assumes the trigger source model and the bound port checker.
`timescale 1ns/100ps
`default_nettype none
module trigger_exposure_control_test;
  logic clk, rst_b, aw_v, w_v, ar_v, aw_rdy, w_rdy, b_v, ar_rdy, r_v, line, b_rdy, r_rdy;
  logic exp_act, ftrig, busy, strobe, oc_oe;
  logic [7:0] aw_a, ar_a;
  logic [3:0] w_s;
  logic [31:0] w_d, d, r_data;
  logic [1:0] r, b_resp, r_resp;
  int cyc, fail_count, checks, elen, slen, last_len, last_slen, frames, t_ft, f, t0, s_off;
  int lat [2];
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // Small exposure and readout counts keep the free-run start short.
  trigger_exposure_control #(.EXPOSURE_RESET(24'h32), .READOUT_RESET(16'h14)) DUT (
    .REF_CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(aw_a), .S_AXI_AWVALID(aw_v),
    .S_AXI_AWREADY(aw_rdy), .S_AXI_WDATA(w_d), .S_AXI_WSTRB(w_s), .S_AXI_WVALID(w_v),
    .S_AXI_WREADY(w_rdy), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_rdy),
    .S_AXI_ARADDR(ar_a), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_rdy), .S_AXI_RDATA(r_data),
    .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_rdy),
    .ISOLATED_TRIGGER_INPUT(line), .OPEN_COLLECTOR_IO_LINE_IN(line & !oc_oe),
    .OPEN_COLLECTOR_IO_LINE_OUT(), .OPEN_COLLECTOR_IO_LINE_OE(oc_oe),
    .EXPOSURE_ACTIVE(exp_act), .FRAME_TRIGGER(ftrig), .FRAME_BUSY(busy), .STROBE(strobe));
  trig_source src (.clk(clk), .line(line));
  // ------
  // Tasks
  // ------
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // Address and data are released separately as each is taken.
  // The leading edge keeps a ready lowered by one call from rising again at that edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    aw_a <= a; w_d <= v; aw_v <= 1'b1; w_v <= 1'b1; b_rdy <= 1'b1;
    do begin
      @(posedge clk);
      if (aw_rdy) aw_v <= 1'b0;
      if (w_rdy) w_v <= 1'b0;
    end while (!b_v);
    b_rdy <= 1'b0;
    r = b_resp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    ar_a <= a; ar_v <= 1'b1; r_rdy <= 1'b1;
    do begin
      @(posedge clk);
      if (ar_rdy) ar_v <= 1'b0;
    end while (!r_v);
    r_rdy <= 1'b0;
    d = r_data;
    r = r_resp;
  endtask
  task automatic idle;
    repeat (6) @(posedge clk);
    while (busy) @(posedge clk);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Pulse lengths and frame count are measured here, with a hang limit.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    elen <= exp_act ? elen + 1 : 0;
    if (!exp_act && elen != 0) last_len <= elen;
    slen <= strobe ? slen + 1 : 0;
    if (!strobe && slen != 0) last_slen <= slen;
    if (strobe && slen == 0) s_off <= cyc - t_ft;
    if (ftrig) begin
      frames <= frames + 1;
      t_ft <= cyc;
    end
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end
  // ------
  // Sequence
  // ------
  initial begin
    rst_b = 0; aw_v = 0; w_v = 0; ar_v = 0; aw_a = 0; ar_a = 0; w_d = 0;
    b_rdy = 0; r_rdy = 0; w_s = 4'hF;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd(trig_pkg::ADDR_CTRL);
    chk("ctrl reset", d, 32'h4);
    rd(trig_pkg::ADDR_DEBOUNCE);
    chk("debounce reset", d, 32'(trig_pkg::DEBOUNCE_RESET));
    wr(8'h20, 32'h0);
    chk("unmapped write", 32'(r), 32'(trig_pkg::RESP_SLVERR));
    rd(8'h22);
    chk("unmapped read", 32'(r), 32'(trig_pkg::RESP_SLVERR));
    wr(trig_pkg::ADDR_DEBOUNCE, 32'h4);
    wr(trig_pkg::ADDR_EXPOSURE, 32'h1E);
    wr(trig_pkg::ADDR_TRIG_DELAY, 32'h0006_0003);
    wr(trig_pkg::ADDR_READOUT, 32'hA);
    wr(trig_pkg::ADDR_STROBE_START_OFFSET, 32'h2);
    wr(trig_pkg::ADDR_STROBE_LENGTH, 32'h5);
    rd(trig_pkg::ADDR_EXPOSURE);
    chk("exposure", d, 32'h1E);
    chk("read resp", 32'(r), 32'(trig_pkg::RESP_OKAY));
    $display("test registers done");
    // A polarity switch may start one stray frame; idle() lets it end before counting.
    for (int p = 1; p >= 0; p--) begin
      wr(trig_pkg::ADDR_CTRL, 32'h22 | (p << 2));
      src.set_idle(p == 0);
      idle();
      f = frames;
      t0 = cyc;
      src.pulse(p == 1, 8);
      idle();
      lat[p] = t_ft - t0;
      chk("edge exposure", last_len, 30);
      chk("strobe length", last_slen, 5);
      chk("strobe offset", s_off, 2);
      chk("edge frames", frames, f + 1);
    end
    chk("delay gap", lat[0] - lat[1], 3);
    $display("test edge preset done");
    // Only byte lane 0 may land: the negative delay keeps its old value.
    w_s <= 4'h1;
    wr(trig_pkg::ADDR_TRIG_DELAY, 32'h0009_0004);
    w_s <= 4'hF;
    rd(trig_pkg::ADDR_TRIG_DELAY);
    chk("strobe lanes", d, 32'h0006_0004);
    for (int i = 0; i < 2; i++) begin
      wr(trig_pkg::ADDR_CTRL, i ? 32'h9 : 32'h5);
      src.set_idle(i == 1);
      idle();
      src.pulse(i == 0, i ? 13 : 17);
      idle();
      chk("pulse exposure", last_len, i ? 13 : 17);
    end
    $display("test pulse width done");
    wr(trig_pkg::ADDR_CTRL, 32'h6);
    src.set_idle(1'b0);
    idle();
    f = frames;
    src.pulse(1'b1, 3);
    idle();
    chk("short pulse", frames, f);
    src.pulse(1'b1, 4);
    idle();
    chk("debounce pulse", frames, f + 1);
    $display("test debounce done");
    wr(trig_pkg::ADDR_CTRL, 32'h7);
    idle();
    f = frames;
    src.pulse(1'b1, 6);
    repeat (10) @(posedge clk);
    src.pulse(1'b1, 6);
    idle();
    chk("guarded frames", frames, f + 1);
    $display("test guarded done");
    f = frames;
    wr(trig_pkg::ADDR_CTRL, 32'h16);
    idle();
    chk("soft trigger", frames, f + 1);
    chk("soft strobe", s_off, 2);
    rd(trig_pkg::ADDR_STATUS);
    chk("status", d, frames << 16);
    $display("test soft trigger done");
    test_done();
  end
endmodule
bind trigger_exposure_control trigger_exposure_control_assertions chk_u (.REF_CLK, .RST_B,
  .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA,
  .EXPOSURE_ACTIVE, .FRAME_TRIGGER, .FRAME_BUSY, .OPEN_COLLECTOR_IO_LINE_OUT,
  .OPEN_COLLECTOR_IO_LINE_OE);
`default_nettype wire
